/* File: rtl/tgcsr_bank.sv */
// module: trap cause, interrupt enable/pending and clock gating override csrs
`timescale 1ns/100ps

module tgcsr_bank #(
    parameter int CGW = tgcsr_pkg::CG_WIDTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire tgcsr_pkg::tg_csr_req_type csr_req,
    output logic [31:0] csr_rdata,
    output logic csr_rvalid,
    output logic csr_hit,
    input wire tgcsr_pkg::tg_irq_type irq_in,
    input wire tgcsr_pkg::tg_trap_type trap_in,
    output logic [CGW-1:0] clk_gate_override,
    output logic int_take_req,
    output logic [4:0] int_take_code,
    output logic [31:0] trap_cause
);

    // ****************************************
    // storage
    // ****************************************
    logic [CGW-1:0] cg_reg, cg_next;
    logic ce_irq_enable_reg, ce_irq_enable_next;
    logic int_timer0_irq_enable_reg, int_timer0_irq_enable_next;
    logic int_timer1_irq_enable_reg, int_timer1_irq_enable_next;
    logic ext_irq_enable_reg, ext_irq_enable_next;
    logic timer_irq_enable_reg, timer_irq_enable_next;
    logic soft_irq_enable_reg, soft_irq_enable_next;
    logic ce_irq_pending_reg, ce_irq_pending_next;
    logic int_timer0_irq_pending_reg, int_timer0_irq_pending_next;
    logic int_timer1_irq_pending_reg, int_timer1_irq_pending_next;
    logic ext_irq_pending_reg, ext_irq_pending_next;
    logic timer_irq_pending_reg, timer_irq_pending_next;
    logic [31:0] cause_reg, cause_next;
    logic [31:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic take_reg, take_next;
    logic [4:0] take_code_reg, take_code_next;

    logic [31:0] ie_view, ip_view, rd_mux;
    logic hit;
    logic soft_irq_line;

    // ****************************************
    // legality of a cause value
    // ****************************************
    // exception codes that trap logic may report
    function automatic logic exc_code_ok(input logic [4:0] c);
        logic ok;
        ok = (c >= tgcsr_pkg::CODE_EXC_MIN && c <= tgcsr_pkg::CODE_EXC_MAX) || c == tgcsr_pkg::CODE_ECALL;
        return ok;
    endfunction

    // standard and local interrupt codes
    function automatic logic int_code_ok(input logic [4:0] c);
        logic ok;
        ok = c == tgcsr_pkg::CODE_TIMER || c == tgcsr_pkg::CODE_EXT ||
             c == tgcsr_pkg::CODE_ITIM1 || c == tgcsr_pkg::CODE_ITIM0 ||
             c == tgcsr_pkg::CODE_CE;
        return ok;
    endfunction

    function automatic logic cause_legal(input logic [31:0] v);
        logic ok;
        ok = 1'b0;
        // RULE_16 only listed encodings
        if (v == tgcsr_pkg::CAUSE_NMI_PIN || v == tgcsr_pkg::CAUSE_NMI_STORE ||
            v == tgcsr_pkg::CAUSE_NMI_LOAD) begin
            ok = 1'b1;
        end else if (v[31:5] == 27'h0) begin
            ok = exc_code_ok(v[4:0]);
        end else if (v[31:5] == tgcsr_pkg::CAUSE_INT_FLAG[31:5]) begin
            ok = int_code_ok(v[4:0]);
        end
        return ok;
    endfunction

    // trap record to cause value; returns legal flag through valid bit
    function automatic logic [32:0] trap_cause_of(input tgcsr_pkg::tg_trap_type t);
        logic [31:0] v;
        logic ok;
        v = tgcsr_pkg::RESET_VALUE;
        ok = 1'b0;
        unique case (t.kind)
            // RULE_12 exception causes, bit 31 clear
            tgcsr_pkg::TG_KIND_EXC: begin
                // code 0 would alias the nmi pin value, so it is refused
                if (exc_code_ok(t.code)) begin
                    v = {27'h0, t.code};
                end else begin
                    v = 32'hFFFF_FFFF;
                end
            end
            // RULE_13 interrupt causes with bit 31 set
            // RULE_14 local interrupt codes 28 to 30
            tgcsr_pkg::TG_KIND_INT: begin
                if (int_code_ok(t.code)) begin
                    v = tgcsr_pkg::CAUSE_INT_FLAG | {27'h0, t.code};
                end else begin
                    v = 32'hFFFF_FFFF;
                end
            end
            // RULE_15 nmi encodings
            tgcsr_pkg::TG_KIND_NMI: begin
                if (t.code == tgcsr_pkg::CODE_NMI_PIN) begin
                    v = tgcsr_pkg::CAUSE_NMI_PIN;
                end else if (t.code == tgcsr_pkg::CODE_NMI_STORE) begin
                    v = tgcsr_pkg::CAUSE_NMI_STORE;
                end else if (t.code == tgcsr_pkg::CODE_NMI_LOAD) begin
                    v = tgcsr_pkg::CAUSE_NMI_LOAD;
                end else begin
                    v = 32'hFFFF_FFFF;
                end
            end
            default: begin
                v = 32'hFFFF_FFFF;
            end
        endcase
        ok = cause_legal(v);
        return {ok, v};
    endfunction

    // ****************************************
    // read views
    // ****************************************
    // software interrupt request is permanently absent
    assign soft_irq_line = 1'b0;

    always_comb begin
        ie_view = tgcsr_pkg::RESET_VALUE;
        ip_view = tgcsr_pkg::RESET_VALUE;
        // RULE_05 local enable positions
        ie_view[tgcsr_pkg::BIT_CE] = ce_irq_enable_reg;
        ie_view[tgcsr_pkg::BIT_ITIM0] = int_timer0_irq_enable_reg;
        ie_view[tgcsr_pkg::BIT_ITIM1] = int_timer1_irq_enable_reg;
        // RULE_06 standard enable positions
        ie_view[tgcsr_pkg::BIT_EXT] = ext_irq_enable_reg;
        ie_view[tgcsr_pkg::BIT_TIMER] = timer_irq_enable_reg;
        ie_view[tgcsr_pkg::BIT_SOFT] = soft_irq_enable_reg;
        // RULE_07 local pending positions
        ip_view[tgcsr_pkg::BIT_CE] = ce_irq_pending_reg;
        ip_view[tgcsr_pkg::BIT_ITIM0] = int_timer0_irq_pending_reg;
        ip_view[tgcsr_pkg::BIT_ITIM1] = int_timer1_irq_pending_reg;
        // RULE_08 external and timer pending, low bits zero
        ip_view[tgcsr_pkg::BIT_EXT] = ext_irq_pending_reg;
        ip_view[tgcsr_pkg::BIT_TIMER] = timer_irq_pending_reg;
    end

    always_comb begin
        hit = 1'b1;
        rd_mux = tgcsr_pkg::RESET_VALUE;
        unique case (csr_req.addr)
            // RULE_09 only machine bits exist in these views
            tgcsr_pkg::ADDR_INT_ENABLE: rd_mux = ie_view & tgcsr_pkg::IE_MASK;
            tgcsr_pkg::ADDR_INT_PENDING: rd_mux = ip_view & tgcsr_pkg::IP_MASK;
            tgcsr_pkg::ADDR_TRAP_CAUSE: rd_mux = cause_reg;
            // RULE_03 upper bits read zero
            tgcsr_pkg::ADDR_CLK_GATE: rd_mux = {{(32 - CGW){1'b0}}, cg_reg} & tgcsr_pkg::CG_MASK;
            default: hit = 1'b0;
        endcase
    end

    // ****************************************
    // armed interrupt lines
    // ****************************************
    // index order is the take priority: ext, ce, timer 0, timer 1, timer
    logic [4:0] line_pending;
    logic [4:0] line_enable;
    logic [4:0] armed;

    assign line_pending = {ext_irq_pending_reg, ce_irq_pending_reg, int_timer0_irq_pending_reg,
        int_timer1_irq_pending_reg, timer_irq_pending_reg};
    assign line_enable = {ext_irq_enable_reg, ce_irq_enable_reg, int_timer0_irq_enable_reg,
        int_timer1_irq_enable_reg, timer_irq_enable_reg};

    // RULE_18 armed needs pending and enable
    for (genvar i = 0; i < 5; i++) begin : g_armed
        assign armed[i] = line_pending[i] && line_enable[i];
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic [32:0] tc;
        logic wr_ie, wr_cause, wr_cg;
        logic trap_load, sw_load;
        tc = trap_cause_of(trap_in);
        wr_ie = csr_req.wr && csr_req.addr == tgcsr_pkg::ADDR_INT_ENABLE;
        wr_cause = csr_req.wr && csr_req.addr == tgcsr_pkg::ADDR_TRAP_CAUSE;
        wr_cg = csr_req.wr && csr_req.addr == tgcsr_pkg::ADDR_CLK_GATE;
        trap_load = trap_in.valid && tc[32];
        sw_load = wr_cause && cause_legal(csr_req.wdata);

        // RULE_01 override bits written by firmware
        // RULE_02 bit 8 down to 0 kept, others dropped
        cg_next = wr_cg ? csr_req.wdata[CGW-1:0] : cg_reg;

        // RULE_04 any value accepted, only implemented bits kept
        ce_irq_enable_next = wr_ie ? csr_req.wdata[tgcsr_pkg::BIT_CE] : ce_irq_enable_reg;
        int_timer0_irq_enable_next = wr_ie ? csr_req.wdata[tgcsr_pkg::BIT_ITIM0] : int_timer0_irq_enable_reg;
        int_timer1_irq_enable_next = wr_ie ? csr_req.wdata[tgcsr_pkg::BIT_ITIM1] : int_timer1_irq_enable_reg;
        ext_irq_enable_next = wr_ie ? csr_req.wdata[tgcsr_pkg::BIT_EXT] : ext_irq_enable_reg;
        timer_irq_enable_next = wr_ie ? csr_req.wdata[tgcsr_pkg::BIT_TIMER] : timer_irq_enable_reg;
        // RULE_10 stored and readable only
        soft_irq_enable_next = wr_ie ? csr_req.wdata[tgcsr_pkg::BIT_SOFT] : soft_irq_enable_reg;

        // RULE_17 pending follows sources, writes ignored
        ce_irq_pending_next = irq_in.ce;
        int_timer0_irq_pending_next = irq_in.itim0;
        int_timer1_irq_pending_next = irq_in.itim1;
        ext_irq_pending_next = irq_in.ext;
        timer_irq_pending_next = irq_in.timer;

        // RULE_11 illegal writes leave the old value
        // hardware trap entry wins over a software write in the same cycle
        cause_next = cause_reg;
        if (trap_load) begin
            cause_next = tc[31:0];
        end else if (sw_load) begin
            cause_next = csr_req.wdata;
        end

        rvalid_next = csr_req.rd;
        rdata_next = csr_req.rd ? rd_mux : rdata_reg;

        // RULE_18 pending and enable both required
        // fixed priority: external, correctable error, timer 0, timer 1, timer
        take_next = 1'b1;
        if (armed[4]) begin
            take_code_next = tgcsr_pkg::CODE_EXT;
        end else if (armed[3]) begin
            take_code_next = tgcsr_pkg::CODE_CE;
        end else if (armed[2]) begin
            take_code_next = tgcsr_pkg::CODE_ITIM0;
        end else if (armed[1]) begin
            take_code_next = tgcsr_pkg::CODE_ITIM1;
        end else if (armed[0]) begin
            take_code_next = tgcsr_pkg::CODE_TIMER;
        end else begin
            take_next = soft_irq_line && soft_irq_enable_reg;
            take_code_next = 5'h00;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cg_reg <= '0;
            ce_irq_enable_reg <= 1'b0;
            int_timer0_irq_enable_reg <= 1'b0;
            int_timer1_irq_enable_reg <= 1'b0;
            ext_irq_enable_reg <= 1'b0;
            timer_irq_enable_reg <= 1'b0;
            soft_irq_enable_reg <= 1'b0;
            ce_irq_pending_reg <= 1'b0;
            int_timer0_irq_pending_reg <= 1'b0;
            int_timer1_irq_pending_reg <= 1'b0;
            ext_irq_pending_reg <= 1'b0;
            timer_irq_pending_reg <= 1'b0;
            // zero is the nmi pin cause, so a legal value from reset
            cause_reg <= tgcsr_pkg::RESET_VALUE;
            rdata_reg <= tgcsr_pkg::RESET_VALUE;
            rvalid_reg <= 1'b0;
            take_reg <= 1'b0;
            take_code_reg <= 5'h00;
        end else begin
            cg_reg <= cg_next;
            ce_irq_enable_reg <= ce_irq_enable_next;
            int_timer0_irq_enable_reg <= int_timer0_irq_enable_next;
            int_timer1_irq_enable_reg <= int_timer1_irq_enable_next;
            ext_irq_enable_reg <= ext_irq_enable_next;
            timer_irq_enable_reg <= timer_irq_enable_next;
            soft_irq_enable_reg <= soft_irq_enable_next;
            ce_irq_pending_reg <= ce_irq_pending_next;
            int_timer0_irq_pending_reg <= int_timer0_irq_pending_next;
            int_timer1_irq_pending_reg <= int_timer1_irq_pending_next;
            ext_irq_pending_reg <= ext_irq_pending_next;
            timer_irq_pending_reg <= timer_irq_pending_next;
            cause_reg <= cause_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            take_reg <= take_next;
            take_code_reg <= take_code_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // RULE_01 override high keeps the unit clock running
    assign clk_gate_override = cg_reg;
    assign csr_rdata = rdata_reg;
    assign csr_rvalid = rvalid_reg;
    assign csr_hit = hit;
    assign int_take_req = take_reg;
    assign int_take_code = take_code_reg;
    assign trap_cause = cause_reg;

endmodule

/* File: rtl/tgcsr_pkg.sv */
// package: constants and types for the trap and clock gating csr bank
// Functional notes
// RULE_01: clock gating overrides reset off; 1 keeps unit clock running, 0 allows gating.
// RULE_02: override bits misc 8, dec 7, exu 6, ifu 5, lsu 4, bus 3, pic 2, dccm 1, iccm 0.
// RULE_03: reserved bits are hardwired zero; reads give 0, writes do nothing.
// RULE_04: read/write registers accept any write, read back only legal values.
// RULE_05: enable bits 30 correctable error, 29 timer 0, 28 timer 1, reset 0.
// RULE_06: enable bits 11 external, 7 timer, 3 software; others read zero.
// RULE_07: pending bits 30 correctable error, 29 timer 0, 28 timer 1, reset 0.
// RULE_08: pending bits 11 external, 7 timer; bits 6 to 0 read zero.
// RULE_09: machine mode only; no supervisor or user enable or pending bits.
// RULE_10: software enable bit is stored and readable but has no effect.
// RULE_11: trap cause register keeps only legal values on write and read.
// RULE_12: exception causes 1-7 and 11 recorded with bit 31 clear.
// RULE_13: timer interrupt cause 0x80000007, external interrupt cause 0x8000000B.
// RULE_14: local interrupt causes 28 timer 1, 29 timer 0, 30 correctable error.
// RULE_15: nmi causes: pin 0, store error 0xF0000000, load error 0xF0000001.
// RULE_16: unlisted cause encodings are never produced by the device.
// RULE_17: pending bits follow their sources; software writes do not change them.
// RULE_18: interrupt is taken only when pending and enable are both set.
package tgcsr_pkg;

    // ****************************************
    // csr addresses
    // ****************************************
    localparam logic [11:0] ADDR_INT_ENABLE = 12'h304;
    localparam logic [11:0] ADDR_TRAP_CAUSE = 12'h342;
    localparam logic [11:0] ADDR_INT_PENDING = 12'h344;
    localparam logic [11:0] ADDR_CLK_GATE = 12'h7F8;

    // ****************************************
    // field positions and masks
    // ****************************************
    localparam int CG_WIDTH = 9;
    localparam logic [31:0] CG_MASK = 32'h0000_01FF;
    localparam int BIT_CE = 30;
    localparam int BIT_ITIM0 = 29;
    localparam int BIT_ITIM1 = 28;
    localparam int BIT_EXT = 11;
    localparam int BIT_TIMER = 7;
    localparam int BIT_SOFT = 3;
    localparam logic [31:0] IE_MASK = 32'h7000_0888;
    localparam logic [31:0] IP_MASK = 32'h7000_0880;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

    // ****************************************
    // trap cause encodings
    // ****************************************
    localparam logic [31:0] CAUSE_INT_FLAG = 32'h8000_0000;
    localparam logic [31:0] CAUSE_NMI_PIN = 32'h0000_0000;
    localparam logic [31:0] CAUSE_NMI_STORE = 32'hF000_0000;
    localparam logic [31:0] CAUSE_NMI_LOAD = 32'hF000_0001;
    localparam logic [4:0] CODE_TIMER = 5'h07;
    localparam logic [4:0] CODE_EXT = 5'h0B;
    localparam logic [4:0] CODE_ITIM1 = 5'h1C;
    localparam logic [4:0] CODE_ITIM0 = 5'h1D;
    localparam logic [4:0] CODE_CE = 5'h1E;
    localparam logic [4:0] CODE_ECALL = 5'h0B;
    localparam logic [4:0] CODE_EXC_MIN = 5'h01;
    localparam logic [4:0] CODE_EXC_MAX = 5'h07;
    localparam logic [4:0] CODE_NMI_PIN = 5'h00;
    localparam logic [4:0] CODE_NMI_STORE = 5'h01;
    localparam logic [4:0] CODE_NMI_LOAD = 5'h02;

    typedef enum logic [2:0] {
        TG_KIND_EXC = 3'h1,
        TG_KIND_INT = 3'h2,
        TG_KIND_NMI = 3'h4
    } tg_kind_type;

    // csr access from the instruction pipeline
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } tg_csr_req_type;

    // trap entry record from trap logic
    typedef struct packed {
        logic valid;
        tg_kind_type kind;
        logic [4:0] code;
    } tg_trap_type;

    // interrupt request lines
    typedef struct packed {
        logic ce;
        logic itim0;
        logic itim1;
        logic ext;
        logic timer;
    } tg_irq_type;

endpackage

/* File: testbench/tgcsr_bank_chk.sv */
// checker: port-level relations of the trap and clock gating csr bank
`timescale 1ns/100ps

module tgcsr_bank_chk #(
    parameter int CGW = tgcsr_pkg::CG_WIDTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire tgcsr_pkg::tg_csr_req_type csr_req,
    input wire logic [31:0] csr_rdata,
    input wire logic csr_rvalid,
    input wire logic csr_hit,
    input wire tgcsr_pkg::tg_irq_type irq_in,
    input wire tgcsr_pkg::tg_trap_type trap_in,
    input wire logic [CGW-1:0] clk_gate_override,
    input wire logic int_take_req,
    input wire logic [4:0] int_take_code,
    input wire logic [31:0] trap_cause
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ****************************************
    // access steps
    // ****************************************
    sequence s_read;
        csr_req.rd;
    endsequence
    sequence s_cg_write;
        csr_req.wr && csr_req.addr == 12'h7F8;
    endsequence
    sequence s_trap(logic [2:0] k);
        trap_in.valid && trap_in.kind == k;
    endsequence

    chk_read_pulse: assert property (s_read |=> csr_rvalid ##1 (csr_rvalid == $past(csr_req.rd)))
        else $error("read valid pulse wrong");
    chk_unmapped_zero: assert property (s_read ##0 !csr_hit |=> csr_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_enable_reserved: assert property (s_read ##0 csr_req.addr == 12'h304 |=> (csr_rdata & 32'h8FFF_F777) == 32'h0)
        else $error("enable reserved bit set");
    chk_pend_reserved: assert property (s_read ##0 csr_req.addr == 12'h344 |=> (csr_rdata & 32'h8FFF_F77F) == 32'h0)
        else $error("pending reserved bit set");
    chk_gate_write: assert property (s_cg_write |=> ({23'h0, clk_gate_override} == ($past(csr_req.wdata) & 32'h1FF)))
        else $error("gate override not written");
    chk_take_source: assert property (int_take_req |-> $past(irq_in, 2) != 5'h00)
        else $error("interrupt taken without source");
    chk_take_code: assert property (!int_take_req |-> int_take_code == 5'h00)
        else $error("code without take");
    chk_cause_legal: assert property (trap_cause inside {32'h0, [32'h1:32'h7], 32'hB, 32'h8000_0007, 32'h8000_000B,
        [32'h8000_001C:32'h8000_001E], 32'hF000_0000, 32'hF000_0001})
        else $error("illegal trap cause");
    chk_int_cause: assert property (s_trap(3'h2) ##0 trap_in.code inside {5'h07, 5'h0B, [5'h1C:5'h1E]}
        |=> trap_cause == {1'b1, 26'h0, $past(trap_in.code)})
        else $error("interrupt cause wrong");
    chk_exc_cause: assert property (s_trap(3'h1) ##0 trap_in.code inside {[5'h01:5'h07], 5'h0B}
        |=> trap_cause == {27'h0, $past(trap_in.code)})
        else $error("exception cause wrong");
endmodule

bind tgcsr_bank tgcsr_bank_chk #(.CGW(CGW)) u_chk (.clk(clk), .rst(rst), .csr_req(csr_req), .csr_rdata(csr_rdata),
    .csr_rvalid(csr_rvalid), .csr_hit(csr_hit), .irq_in(irq_in), .trap_in(trap_in),
    .clk_gate_override(clk_gate_override), .int_take_req(int_take_req), .int_take_code(int_take_code),
    .trap_cause(trap_cause));

/* File: testbench/testbench.sv */
// testbench: self-checking run of the trap and clock gating csr bank
`timescale 1ns/100ps

module testbench;
    logic clk;
    logic rst;
    tgcsr_pkg::tg_csr_req_type csr_req;
    tgcsr_pkg::tg_irq_type irq_in;
    tgcsr_pkg::tg_trap_type trap_in;
    logic [31:0] csr_rdata;
    logic [31:0] trap_cause;
    logic csr_rvalid;
    logic csr_hit;
    logic int_take_req;
    logic [4:0] int_take_code;
    logic [8:0] clk_gate_override;
    logic [31:0] ie_m;
    logic [31:0] cg_m;
    logic [31:0] tc_m;
    logic [15:0] lfsr_q;
    logic [11:0] addrs [5] = '{12'h304, 12'h342, 12'h344, 12'h7F8, 12'h7F9};
    logic [2:0] kinds [3] = '{3'h1, 3'h2, 3'h4};
    int miscompares;
    int samples_checked;
    int cycles;

    tgcsr_bank u_tgcsr_bank (.clk(clk), .rst(rst), .csr_req(csr_req), .csr_rdata(csr_rdata),
        .csr_rvalid(csr_rvalid), .csr_hit(csr_hit), .irq_in(irq_in), .trap_in(trap_in),
        .clk_gate_override(clk_gate_override), .int_take_req(int_take_req), .int_take_code(int_take_code),
        .trap_cause(trap_cause));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] q);
        return {q[14:0], q[15] ^ q[13] ^ q[12] ^ q[10]};
    endfunction

    // ****************************************
    // reference model
    // ****************************************
    function automatic logic [31:0] pend_m();
        return {1'b0, irq_in.ce, irq_in.itim0, irq_in.itim1, 16'h0, irq_in.ext, 3'h0, irq_in.timer, 7'h0};
    endfunction

    function automatic logic [4:0] take_m(input logic [31:0] p);
        if (p[11]) return 5'h0B;
        if (p[30]) return 5'h1E;
        if (p[29]) return 5'h1D;
        if (p[28]) return 5'h1C;
        if (p[7]) return 5'h07;
        return 5'h00;
    endfunction

    // bit 32 marks a legal encoding
    function automatic logic [32:0] cause_of(input logic [2:0] k, input logic [4:0] c);
        if (k == 3'h1 && ((c >= 5'h01 && c <= 5'h07) || c == 5'h0B)) return {1'b1, 27'h0, c};
        if (k == 3'h2 && (c inside {5'h07, 5'h0B, 5'h1C, 5'h1D, 5'h1E})) return {1'b1, 1'b1, 26'h0, c};
        if (k == 3'h4 && c <= 5'h02) return {1'b1, (c == 5'h00) ? 32'h0 : {4'hF, 27'h0, c[1]}};
        return 33'h0;
    endfunction

    function automatic logic legal_cause(input logic [31:0] v);
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 32; c++) begin
                if (cause_of(kinds[k], 5'(c)) === {1'b1, v}) return 1'b1;
            end
        end
        return 1'b0;
    endfunction

    function automatic logic [31:0] reg_m(input logic [11:0] a);
        case (a)
            12'h304: return ie_m;
            12'h342: return tc_m;
            12'h344: return pend_m();
            12'h7F8: return cg_m;
            default: return 32'h0;
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic access(input logic rd_i, input logic wr_i, input logic [11:0] a, input logic [31:0] d);
        logic [31:0] exp;
        exp = reg_m(a);
        @(posedge clk);
        csr_req <= '{rd: rd_i, wr: wr_i, addr: a, wdata: d};
        #1 check("hit", {31'h0, a inside {12'h304, 12'h342, 12'h344, 12'h7F8}}, {31'h0, csr_hit});
        @(posedge clk);
        csr_req <= '0;
        // reserved bits dropped, illegal cause kept out
        if (wr_i && a == 12'h304) ie_m = d & tgcsr_pkg::IE_MASK;
        if (wr_i && a == 12'h7F8) cg_m = d & tgcsr_pkg::CG_MASK;
        if (wr_i && a == 12'h342 && legal_cause(d)) tc_m = d;
        #1 check("rvalid", {31'h0, rd_i}, {31'h0, csr_rvalid});
        if (rd_i) check("rdata", exp, csr_rdata);
        check("gate", cg_m, {23'h0, clk_gate_override});
        check("cause", tc_m, trap_cause);
    endtask

    task automatic trap(input logic [2:0] k, input logic [4:0] c);
        logic [32:0] r;
        r = cause_of(k, c);
        @(posedge clk);
        trap_in <= '{valid: 1'b1, kind: tgcsr_pkg::tg_kind_type'(k), code: c};
        @(posedge clk);
        trap_in <= '0;
        if (r[32]) tc_m = r[31:0];
        #1 check("trap cause", tc_m, trap_cause);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            wrap_up();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        csr_req = '0;
        irq_in = '0;
        trap_in = '0;
        lfsr_q = 16'h0019;
        ie_m = 32'h0;
        cg_m = 32'h0;
        tc_m = 32'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        foreach (addrs[i]) access(1'b1, 1'b0, addrs[i], 32'h0);
        foreach (addrs[i]) access(1'b1, 1'b1, addrs[i], 32'hFFFF_FFFF);
        foreach (addrs[i]) access(1'b1, 1'b0, addrs[i], 32'h0);
        repeat (6) begin
            foreach (addrs[i]) begin
                lfsr_q = lfsr(lfsr_q);
                access(1'b1, 1'b1, addrs[i], {lfsr_q, ~lfsr_q});
                access(1'b1, 1'b0, addrs[i], 32'h0);
            end
        end
        access(1'b0, 1'b1, 12'h342, 32'h8000_001C);
        access(1'b1, 1'b1, 12'h342, 32'h0000_000C);
        access(1'b1, 1'b0, 12'h342, 32'h0);
        foreach (kinds[k]) for (int c = 0; c < 32; c++) trap(kinds[k], 5'(c));
        repeat (24) begin
            lfsr_q = lfsr(lfsr_q);
            @(posedge clk);
            irq_in <= lfsr_q[4:0];
            access(1'b0, 1'b1, 12'h304, {1'b0, lfsr_q[2:0], 16'h0, lfsr_q[7], 3'h0, lfsr_q[6], 3'h0, lfsr_q[5], 3'h0});
            access(1'b0, 1'b1, 12'h344, 32'hFFFF_FFFF);
            @(posedge clk);
            #1 check("take code", {27'h0, take_m(pend_m() & ie_m)}, {27'h0, int_take_code});
            check("take", {31'h0, |(pend_m() & ie_m)}, {31'h0, int_take_req});
            access(1'b1, 1'b0, 12'h344, 32'h0);
        end
        wrap_up();
    end
endmodule
